// ===== hdl/two_wire_debug_params.svh
// Function
// [RULE1] Host clock plus one shared data line
// [RULE2] Device keeps 8-bit debug target select
// [RULE3] Select 0x00 reads device identity
// [RULE4] Select 0x01 reads silicon revision
// [RULE5] Select 0x02 accesses flash program control
// [RULE6] Select 0xb4 accesses flash program data
// [RULE7] Flash commands, addresses, data pass through data
// [RULE8] Codes 0x06 block read, 0x07 write
// [RULE9] Codes 0x08 page erase, 0x03 device erase
// [RULE10] Link traffic carried while device halted
// [RULE11] Halted: reset pin clocks, port pin data
// [RULE12] Application never drives reset pin
// [RULE13] Writes to identity registers ignored
`ifndef TWO_WIRE_DEBUG_PARAMS_SVH
`define TWO_WIRE_DEBUG_PARAMS_SVH

// Target select values
`define SEL_DEVICE_IDENTITY 8'h00
`define SEL_SILICON_REVISION 8'h01
`define SEL_FLASH_PROGRAM_CONTROL 8'h02
`define SEL_FLASH_PROGRAM_DATA 8'hb4

// Flash command codes carried in the program data register
`define FLASH_CMD_BLOCK_READ 8'h06
`define FLASH_CMD_BLOCK_WRITE 8'h07
`define FLASH_CMD_PAGE_ERASE 8'h08
`define FLASH_CMD_DEVICE_ERASE 8'h03

// Reset values and the control register full flag bit
`define TARGET_SELECT_RESET 8'h00
`define FLASH_CONTROL_RESET 8'h00
`define FLASH_CONTROL_FULL_BIT 7

// Host register byte offsets and fields
`define HOST_REG_COMMAND 8'h00
`define HOST_REG_STATUS 8'h04
`define HOST_INSTR_LSB 0
`define HOST_BYTE_LSB 8
`define HOST_BUSY_BIT 0

// Link timing
`define HCLK_PERIOD_NS 20
`define LINK_PERIOD_NS 160
`define LINK_HALF_CYCLES (`LINK_PERIOD_NS / `HCLK_PERIOD_NS / 2)
`define LINK_MIN_HALF_CYCLES 4

`endif

// ===== hdl/two_wire_debug_pkg.sv
package two_wire_debug_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [4:0] {
        LINK_IDLE  = 5'b00001,
        LINK_START = 5'b00010,
        LINK_INSTR = 5'b00100,
        LINK_WRITE = 5'b01000,
        LINK_READ  = 5'b10000
    } link_state_e;

    typedef enum logic [1:0] {
        INSTR_DATA_READ  = 2'b00,
        INSTR_DATA_WRITE = 2'b01,
        INSTR_ADDR_READ  = 2'b10,
        INSTR_ADDR_WRITE = 2'b11
    } link_instr_e;

    function automatic logic instr_is_write(input logic [1:0] instr);
        return instr[0];
    endfunction

endpackage

// ===== hdl/two_wire_debug_if.sv
`timescale 1ns/1ns
interface two_wire_debug_if;
    logic debug_link_clock;
    logic host_data_out;
    logic host_data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    logic debug_link_data;

    // Undriven line is held high by the pull-up
    assign debug_link_data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 1'b1);

    modport host (
        output debug_link_clock,
        output host_data_out,
        output host_data_oe,
        input debug_link_data
    );

    modport device (
        input debug_link_clock,
        input debug_link_data,
        output dev_data_out,
        output dev_data_oe
    );
endinterface

// ===== hdl/stream_fifo.sv
`timescale 1ns/1ns
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("stream_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic push, pop;

    always_comb begin
        push = in_valid && in_ready;
        // Output stage refills from memory whenever it is empty or being taken
        pop = (count != '0) && (!out_valid || out_ready);
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
        next_out_data = pop ? mem[rd_ptr] : out_data;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
            in_ready <= next_count != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// ===== hdl/debug_port_device.sv
`timescale 1ns/1ns
`include "two_wire_debug_params.svh"
module debug_port_device
    import two_wire_debug_pkg::*;
#(
    parameter byte_t DEVICE_IDENTITY = 8'h5a, // Arbitrary value
    parameter byte_t SILICON_REVISION = 8'h01, // Arbitrary value
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link side
    two_wire_debug_if.device link,
    // Core state and user pin function
    input wire logic halted,
    input wire logic user_port_out,
    input wire logic user_port_oe,
    output logic user_port_in,
    // Flash engine side
    output logic [7:0] flash_program_control,
    output logic flash_stream_valid,
    output logic [7:0] flash_stream_data,
    input wire logic flash_stream_ready,
    input wire logic [7:0] flash_read_data
);
    link_state_e state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [1:0] instr, next_instr;
    logic [7:0] shift, next_shift;
    logic [7:0] target_select, next_target_select;
    logic [7:0] control, next_control;
    logic push, next_push;
    logic [7:0] push_data, next_push_data;
    logic link_out, next_link_out, link_oe, next_link_oe;
    logic ck_s1, ck_s2, ck_d, d_s1, d_s2;
    logic rise, fall, fifo_in_ready;

    function automatic byte_t read_value(input logic [1:0] ins, input byte_t sel, input byte_t ctl,
                                         input byte_t fdat, input logic full);
        byte_t v;
        v = 8'h00;
        if (ins == INSTR_ADDR_READ) begin
            v = sel;
        end else begin
            case (sel)
                `SEL_DEVICE_IDENTITY: v = DEVICE_IDENTITY; // [RULE3]
                `SEL_SILICON_REVISION: v = SILICON_REVISION; // [RULE4]
                `SEL_FLASH_PROGRAM_CONTROL: begin
                    v = ctl; // [RULE5]
                    v[`FLASH_CONTROL_FULL_BIT] = full;
                end
                `SEL_FLASH_PROGRAM_DATA: v = fdat; // [RULE6]
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    // Pin inputs cross from the host's domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ck_s1 <= 1'b1;
            ck_s2 <= 1'b1;
            ck_d <= 1'b1;
            d_s1 <= 1'b1;
            d_s2 <= 1'b1;
        end else begin
            ck_s1 <= link.debug_link_clock; // [RULE1]
            ck_s2 <= ck_s1;
            ck_d <= ck_s2;
            d_s1 <= link.debug_link_data;
            d_s2 <= d_s1;
        end
    end

    assign rise = ck_s2 && !ck_d;
    assign fall = !ck_s2 && ck_d;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_instr = instr;
        next_shift = shift;
        next_target_select = target_select;
        next_control = control;
        next_push = 1'b0;
        next_push_data = push_data;
        next_link_out = link_out;
        next_link_oe = link_oe;
        if (!halted) begin
            // Link is only served while the core is stalled
            next_state = LINK_IDLE; // [RULE10]
            next_link_oe = 1'b0;
        end else begin
            case (state)
                LINK_IDLE: begin
                    if (rise && !d_s2) begin
                        next_state = LINK_INSTR;
                        next_cnt = 3'd0;
                    end
                end
                LINK_INSTR: begin
                    if (rise) begin
                        next_instr = {instr[0], d_s2};
                        next_cnt = cnt + 3'd1;
                        if (cnt == 3'd1) begin
                            next_cnt = 3'd0;
                            if (instr_is_write({instr[0], d_s2})) begin
                                next_state = LINK_WRITE;
                            end else begin
                                next_state = LINK_READ;
                                next_shift = read_value({instr[0], d_s2}, target_select, control,
                                                        flash_read_data, !fifo_in_ready);
                            end
                        end
                    end
                end
                LINK_WRITE: begin
                    if (rise) begin
                        next_shift = {shift[6:0], d_s2};
                        next_cnt = cnt + 3'd1;
                        if (cnt == 3'd7) begin
                            next_state = LINK_IDLE;
                            if (instr == INSTR_ADDR_WRITE) begin
                                next_target_select = {shift[6:0], d_s2}; // [RULE2]
                            end else if (target_select == `SEL_FLASH_PROGRAM_CONTROL) begin
                                next_control = {shift[6:0], d_s2}; // [RULE5]
                            end else if (target_select == `SEL_FLASH_PROGRAM_DATA && fifo_in_ready) begin
                                // Commands, addresses and data go to the engine as a byte stream
                                next_push = 1'b1; // [RULE6] [RULE7] [RULE8] [RULE9]
                                next_push_data = {shift[6:0], d_s2};
                            end
                            // Identity and revision selects take no write [RULE13]
                        end
                    end
                end
                LINK_READ: begin
                    if (fall) begin
                        next_link_out = shift[7]; // [RULE1]
                        next_link_oe = 1'b1;
                        next_shift = {shift[6:0], 1'b0};
                    end
                    if (rise) begin
                        next_cnt = cnt + 3'd1;
                        if (cnt == 3'd7) begin
                            next_state = LINK_IDLE;
                            next_link_oe = 1'b0;
                        end
                    end
                end
                default: begin
                    next_state = LINK_IDLE;
                    next_link_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= LINK_IDLE;
            cnt <= 3'd0;
            instr <= 2'b00;
            shift <= 8'h00;
            target_select <= `TARGET_SELECT_RESET;
            control <= `FLASH_CONTROL_RESET;
            push <= 1'b0;
            push_data <= 8'h00;
            link_out <= 1'b1;
            link_oe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            instr <= next_instr;
            shift <= next_shift;
            target_select <= next_target_select;
            control <= next_control;
            push <= next_push;
            push_data <= next_push_data;
            link_out <= next_link_out;
            link_oe <= next_link_oe;
        end
    end

    // Shared data pin: debug link while halted, user function otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link.dev_data_out <= 1'b1;
            link.dev_data_oe <= 1'b0;
            user_port_in <= 1'b1;
            flash_program_control <= `FLASH_CONTROL_RESET;
        end else begin
            link.dev_data_out <= halted ? link_out : user_port_out; // [RULE11]
            link.dev_data_oe <= halted ? link_oe : user_port_oe; // [RULE11]
            user_port_in <= d_s2;
            flash_program_control <= next_control;
        end
    end

    stream_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_flash_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(push),
        .in_data(push_data),
        .in_ready(fifo_in_ready),
        .out_valid(flash_stream_valid),
        .out_data(flash_stream_data),
        .out_ready(flash_stream_ready)
    );
endmodule

// ===== hdl/debug_port_host.sv
`timescale 1ns/1ns
`include "two_wire_debug_params.svh"
module debug_port_host
    import two_wire_debug_pkg::*;
#(
    parameter int HALF_CYCLES = `LINK_HALF_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Link side
    two_wire_debug_if.host link
);
    // Device sees a falling edge three cycles late and needs the rest to answer
    if (HALF_CYCLES < `LINK_MIN_HALF_CYCLES || HALF_CYCLES > 255) begin : g_half_check
        $error("debug_port_host half period out of range");
    end

    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic go;
    link_state_e state, next_state;
    logic [7:0] div, next_div;
    logic [2:0] cnt, next_cnt;
    logic [1:0] instr, next_instr;
    logic [7:0] shift, next_shift, rx, next_rx;
    logic ck, next_ck, dout, next_dout, doe, next_doe, busy, next_busy;
    logic d_s1, d_s2, half_end;

    // Bus side: zero wait states, read data captured in the address phase
    always_comb begin
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_hrdata = hrdata;
        go = wr_pend && wr_addr == `HOST_REG_COMMAND && !busy;
        if (hsel && htrans[1] && hready) begin
            next_wr_pend = hwrite;
            next_wr_addr = haddr[7:0];
            next_hrdata = 32'h0000_0000;
            if (!hwrite && haddr[7:0] == `HOST_REG_STATUS) begin
                next_hrdata[`HOST_BUSY_BIT] = busy;
                next_hrdata[`HOST_BYTE_LSB +: 8] = rx;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_s1 <= 1'b1;
            d_s2 <= 1'b1;
        end else begin
            d_s1 <= link.debug_link_data;
            d_s2 <= d_s1;
        end
    end

    assign half_end = div == 8'(HALF_CYCLES - 1);

    // Link side: each bit slot is a low half then a high half of the clock
    always_comb begin
        next_state = state;
        next_div = (state == LINK_IDLE || half_end) ? 8'h00 : div + 8'h01;
        next_cnt = cnt;
        next_instr = instr;
        next_shift = shift;
        next_rx = rx;
        next_ck = ck;
        next_dout = dout;
        next_doe = doe;
        next_busy = busy;
        case (state)
            LINK_IDLE: begin
                next_ck = 1'b1;
                if (go) begin
                    next_state = LINK_START;
                    next_instr = hwdata[`HOST_INSTR_LSB +: 2];
                    next_shift = hwdata[`HOST_BYTE_LSB +: 8];
                    next_ck = 1'b0;
                    next_dout = 1'b0; // [RULE1]
                    next_doe = 1'b1;
                    next_busy = 1'b1;
                end
            end
            default: begin
                if (half_end && !ck) begin
                    next_ck = 1'b1;
                end else if (half_end) begin
                    next_ck = 1'b0;
                    case (state)
                        LINK_START: begin
                            next_state = LINK_INSTR;
                            next_cnt = 3'd0;
                            next_dout = instr[1];
                        end
                        LINK_INSTR: begin
                            if (cnt == 3'd0) begin
                                next_cnt = 3'd1;
                                next_dout = instr[0];
                            end else begin
                                next_cnt = 3'd0;
                                next_state = instr_is_write(instr) ? LINK_WRITE : LINK_READ;
                                next_dout = shift[7];
                                next_shift = {shift[6:0], 1'b0};
                                // Release the line before the device turns it round
                                next_doe = instr_is_write(instr); // [RULE1]
                            end
                        end
                        LINK_WRITE: begin
                            if (cnt == 3'd7) begin
                                next_state = LINK_IDLE;
                                next_ck = 1'b1;
                                next_doe = 1'b0;
                                next_busy = 1'b0;
                            end else begin
                                next_cnt = cnt + 3'd1;
                                next_dout = shift[7];
                                next_shift = {shift[6:0], 1'b0};
                            end
                        end
                        LINK_READ: begin
                            next_rx = {rx[6:0], d_s2};
                            next_cnt = cnt + 3'd1;
                            if (cnt == 3'd7) begin
                                next_state = LINK_IDLE;
                                next_ck = 1'b1;
                                next_busy = 1'b0;
                            end
                        end
                        default: begin
                            next_state = LINK_IDLE;
                            next_ck = 1'b1;
                            next_doe = 1'b0;
                            next_busy = 1'b0;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= LINK_IDLE;
            div <= 8'h00;
            cnt <= 3'd0;
            instr <= 2'b00;
            shift <= 8'h00;
            rx <= 8'h00;
            ck <= 1'b1;
            dout <= 1'b1;
            doe <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            div <= next_div;
            cnt <= next_cnt;
            instr <= next_instr;
            shift <= next_shift;
            rx <= next_rx;
            ck <= next_ck;
            dout <= next_dout;
            doe <= next_doe;
            busy <= next_busy;
        end
    end

    assign link.debug_link_clock = ck;
    assign link.host_data_out = dout;
    assign link.host_data_oe = doe;
endmodule

// ===== test/debug_link_sva.sv
`timescale 1ns/1ns
module debug_link_sva (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link wires
    input wire logic debug_link_clock,
    input wire logic host_data_out,
    input wire logic host_data_oe,
    input wire logic dev_data_out,
    input wire logic dev_data_oe,
    input wire logic debug_link_data
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    no_contention_a: assert property (!(host_data_oe && dev_data_oe))
        else $error("Both ends drive the data line");
    clk_high_len_a: assert property ($rose(debug_link_clock) |-> debug_link_clock[*4])
        else $error("Link clock high half too short");
    clk_low_len_a: assert property ($fell(debug_link_clock) |-> !debug_link_clock[*4] ##1 debug_link_clock)
        else $error("Link clock low half not four cycles");
    host_stable_a: assert property (
        host_data_oe && $past(host_data_oe) && debug_link_clock && $past(debug_link_clock) |-> $stable(host_data_out))
        else $error("Host data moved while clock high");
    dev_stable_a: assert property (
        dev_data_oe && $past(dev_data_oe) && debug_link_clock && $past(debug_link_clock, 2) |-> $stable(dev_data_out))
        else $error("Device data moved late in clock high");
    turnaround_a: assert property ($rose(dev_data_oe) |-> !$past(host_data_oe, 2))
        else $error("No gap between host release and device drive");
    dev_hold_a: assert property ($rose(dev_data_oe) |-> dev_data_oe[*8])
        else $error("Device released the line too early");
    dev_release_a: assert property ($rose(dev_data_oe) |-> ##[40:100] !dev_data_oe)
        else $error("Device kept the line too long");

    cover property ($rose(dev_data_oe));
    cover property ($fell(debug_link_clock));
    cover property ($rose(host_data_oe));
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    import two_wire_debug_pkg::*;
    // Arbitrary identity values, differing from the defaults on purpose
    localparam byte_t ID_VAL = 8'h3c;
    localparam byte_t REV_VAL = 8'h07;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic halted = 1, user_port_out = 0, user_port_oe = 0, user_port_in;
    logic flash_stream_ready = 0, flash_stream_valid;
    logic [7:0] flash_read_data = 8'hc3, flash_stream_data, flash_program_control;
    int error_cnt = 0, num_checks = 0;

    two_wire_debug_if link_if ();
    debug_port_host debug_port_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link_if.host));
    debug_port_device #(.DEVICE_IDENTITY(ID_VAL), .SILICON_REVISION(REV_VAL)) debug_port_device_inst (
        .hclk(hclk), .hresetn(hresetn), .link(link_if.device), .halted(halted), .user_port_out(user_port_out),
        .user_port_oe(user_port_oe), .user_port_in(user_port_in), .flash_program_control(flash_program_control),
        .flash_stream_valid(flash_stream_valid), .flash_stream_data(flash_stream_data),
        .flash_stream_ready(flash_stream_ready), .flash_read_data(flash_read_data));
    debug_link_sva debug_link_sva_inst (.hclk(hclk), .hresetn(hresetn),
        .debug_link_clock(link_if.debug_link_clock), .host_data_out(link_if.host_data_out),
        .host_data_oe(link_if.host_data_oe), .dev_data_out(link_if.dev_data_out),
        .dev_data_oe(link_if.dev_data_oe), .debug_link_data(link_if.debug_link_data));

    always #10 hclk = ~hclk;

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic link(input logic [1:0] ins, input logic [7:0] b, output logic [7:0] rx);
        logic [31:0] r;
        ahb(1'b1, 32'h0, {16'h0, b, 6'h0, ins}, r);
        r = 32'h1;
        for (int i = 0; i < 400 && r[0]; i++) ahb(1'b0, 32'h4, 32'h0, r);
        `CHK(r[0], 1'b0)
        `CHK(hresp, 1'b0)
        rx = r[15:8];
    endtask

    task automatic t_ids;
        logic [7:0] rx;
        link(INSTR_ADDR_WRITE, 8'h00, rx);
        link(INSTR_DATA_READ, 8'h00, rx);
        `CHK(rx, ID_VAL)
        link(INSTR_DATA_WRITE, 8'ha5, rx);
        link(INSTR_DATA_READ, 8'h00, rx);
        `CHK(rx, ID_VAL)
        link(INSTR_ADDR_WRITE, 8'h01, rx);
        link(INSTR_ADDR_READ, 8'h00, rx);
        `CHK(rx, 8'h01)
        link(INSTR_DATA_WRITE, 8'h77, rx);
        link(INSTR_DATA_READ, 8'h00, rx);
        `CHK(rx, REV_VAL)
        // A stray write must reach neither the control register nor the flash stream
        `CHK(flash_program_control, 8'h00)
        `CHK(flash_stream_valid, 1'b0)
    endtask

    task automatic t_ctl;
        logic [7:0] rx;
        logic [31:0] r;
        ahb(1'b0, 32'h8, 32'h0, r);
        `CHK(r, 32'h0)
        link(INSTR_ADDR_WRITE, 8'h02, rx);
        link(INSTR_DATA_WRITE, 8'h35, rx);
        `CHK(flash_program_control, 8'h35)
        link(INSTR_DATA_READ, 8'h00, rx);
        `CHK(rx, 8'h35)
    endtask

    // Far side stalls while the buffer fills, then drains in order
    task automatic t_fifo;
        logic [7:0] rx;
        logic [7:0] codes [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
        logic [7:0] q [$];
        int k;
        rx = 8'h00;
        for (int i = 0; i < 12 && !rx[7]; i++) begin
            q.push_back(i < 4 ? codes[i] : 8'h10 + 8'(i));
            link(INSTR_ADDR_WRITE, 8'hb4, rx);
            link(INSTR_DATA_WRITE, q[i], rx);
            link(INSTR_ADDR_WRITE, 8'h02, rx);
            link(INSTR_DATA_READ, 8'h00, rx);
        end
        `CHK(rx, 8'hb5)
        link(INSTR_ADDR_WRITE, 8'hb4, rx);
        link(INSTR_DATA_WRITE, 8'hee, rx);
        link(INSTR_DATA_READ, 8'h00, rx);
        `CHK(rx, 8'hc3)
        flash_stream_ready <= 1'b1;
        k = 0;
        // Look between edges, so each view is the word taken at the next rising edge
        for (int c = 0; c < 200 && k < q.size(); c++) begin
            @(negedge hclk);
            if (flash_stream_valid === 1'b1) begin
                `CHK(flash_stream_data, q[k])
                k++;
            end
        end
        repeat (3) @(posedge hclk);
        `CHK(flash_stream_valid, 1'b0)
        `CHK(k, q.size())
        flash_stream_ready <= 1'b0;
    endtask

    task automatic t_pin;
        logic [7:0] rx;
        halted <= 1'b0;
        user_port_oe <= 1'b1;
        repeat (50) @(posedge hclk);
        `CHK(link_if.debug_link_data, 1'b0)
        `CHK(user_port_in, 1'b0)
        // The user side never drives the clock pin, so it stays at the host's idle level
        `CHK(link_if.debug_link_clock, 1'b1)
        user_port_oe <= 1'b0;
        repeat (8) @(posedge hclk);
        `CHK(user_port_in, 1'b1)
        link(INSTR_DATA_READ, 8'h00, rx);
        `CHK(rx, 8'hff)
        halted <= 1'b1;
    endtask

    task complete_run;
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_ids;
        t_ctl;
        t_fifo;
        t_pin;
        complete_run;
    end

    initial begin
        repeat (60000) @(posedge hclk);
        error_cnt++;
        complete_run;
    end
endmodule
